/* core/rtc_pkg.sv */
package rtc_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int USER_BYTES = 32752;
  localparam logic [14:0] CENTURY_OFS = 15'h7FF1;
  localparam logic [14:0] AL_DATE_OFS = 15'h7FF2;
  localparam logic [14:0] AL_HOUR_OFS = 15'h7FF3;
  localparam logic [14:0] AL_MIN_OFS = 15'h7FF4;
  localparam logic [14:0] AL_SEC_OFS = 15'h7FF5;
  localparam logic [14:0] FLAGS_OFS = 15'h7FF6;
  localparam logic [14:0] WDOG_OFS = 15'h7FF7;
  localparam logic [14:0] CTRL_OFS = 15'h7FF8;
  localparam logic [14:0] SEC_OFS = 15'h7FF9;
  localparam logic [14:0] MIN_OFS = 15'h7FFA;
  localparam logic [14:0] HOUR_OFS = 15'h7FFB;
  localparam logic [14:0] DAY_OFS = 15'h7FFC;
  localparam logic [14:0] DATE_OFS = 15'h7FFD;
  localparam logic [14:0] MONTH_OFS = 15'h7FFE;
  localparam logic [14:0] YEAR_OFS = 15'h7FFF;
  localparam int CTRL_WRITE_BIT = 7;
  localparam int CTRL_READ_BIT = 6;
  localparam int CTRL_SIGN_BIT = 5;
  localparam int FLAG_AL_EN_BIT = 7;
  localparam int FLAG_AL_BIT = 0;
  localparam int FLAG_WD_BIT = 1;
  localparam int WDOG_STEER_BIT = 7;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] ONE_RST = 8'h01;
  localparam logic [7:0] CENTURY_RST = 8'h20;
  localparam int CLK_NS = 20;
  localparam int ADDR_ACCESS_NS = 70;
  localparam int SELECT_ACCESS_NS = 70;
  localparam int OUTPUT_ACCESS_NS = 30;
  localparam int OUTPUT_HOLD_NS = 5;
  localparam logic [2:0] ADDR_ACCESS_CYC = 3'(ADDR_ACCESS_NS / CLK_NS);
  localparam logic [2:0] SELECT_ACCESS_CYC = 3'(SELECT_ACCESS_NS / CLK_NS);
  localparam logic [2:0] OUTPUT_ACCESS_CYC = 3'(OUTPUT_ACCESS_NS / CLK_NS);
  localparam logic [2:0] OUTPUT_HOLD_CYC =
    3'((OUTPUT_HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] FILL_BYTE = 8'h00;
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_HOLD = 2'b01,
    RD_WAIT = 2'b10,
    RD_VALID = 2'b11
  } rd_state_t;
endpackage : rtc_pkg

/* core/rtc_sram_parallel_port.sv */
`timescale 1ns/1ns
module rtc_sram_parallel_port import rtc_pkg::*; #(
  parameter int SEC_CYC = 50_000_000,
  parameter int CAL_STEP_CYC = 8,
  parameter int WDOG_UNIT_CYC = 50_000,
  parameter int WDOG_RST_CYC = 2_000_000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [14:0] addr_bus,
  input wire logic [7:0] data_bus_in,
  output logic [7:0] data_bus_out,
  output logic data_bus_oe,
  input wire logic chip_en_n,
  input wire logic out_en_n,
  input wire logic write_en_n,
  input wire logic power_fail,
  input wire logic battery_mode,
  input wire logic watchdog_kick_in,
  output logic alarm_or_freq_test_n_out,
  output logic alarm_or_freq_test_n_oe,
  output logic wdog_reset_n_out,
  output logic wdog_reset_n_oe
);
  // ---------------------------------------------
  // pin synchronisers
  // ---------------------------------------------
  logic [29:0] s1_reg, s2_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg <= {15'h0000, 8'h00, 7'h70};
      s2_reg <= {15'h0000, 8'h00, 7'h70};
    end else begin
      s1_reg <= {addr_bus, data_bus_in, chip_en_n, out_en_n, write_en_n,
                 power_fail, battery_mode, watchdog_kick_in, 1'b0};
      s2_reg <= s1_reg;
    end
  end
  logic [14:0] addr;
  logic [7:0] din;
  logic ce, oe, we, pf, kick;
  assign addr = s2_reg[29:15];
  assign din = s2_reg[14:7];
  assign ce = ~s2_reg[6];
  assign oe = ~s2_reg[5];
  assign we = ~s2_reg[4];
  assign pf = s2_reg[3] | s2_reg[2];
  assign kick = s2_reg[1];

  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9)
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    else
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
  endfunction : bcd_inc
  function automatic logic [7:0] month_days(input logic [7:0] mon,
                                            input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    case (mon)
      8'h02: month_days = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_days = 8'h30;
      default: month_days = 8'h31;
    endcase
  endfunction : month_days

  // ---------------------------------------------
  // host writes and memory
  // ---------------------------------------------
  logic [7:0] mem [0:USER_BYTES-1];
  logic [7:0] tk_reg [0:7];
  logic [7:0] al_reg [0:3];
  logic [7:0] wdog_reg, ctrl_reg, flags_reg;
  logic wr_ok;
  logic [2:0] tk_idx;
  // write gate under supply fault
  // writes blocked
  assign wr_ok = ce & we & ~pf;
  assign tk_idx = (addr == CENTURY_OFS) ? 3'd7 : 3'(addr - SEC_OFS);

  always_ff @(posedge clk) begin
    if (wr_ok && 32'(addr) < USER_BYTES)
      mem[addr] <= din;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 4; i++)
        al_reg[i] <= BYTE_RST;
    end else if (wr_ok && addr >= AL_DATE_OFS && addr <= AL_SEC_OFS) begin
      al_reg[2'(addr - AL_DATE_OFS)] <= din;
    end
  end

  always_ff @(posedge clk) begin
    if (rst)
      ctrl_reg <= BYTE_RST;
    else if (wr_ok && addr == CTRL_OFS)
      ctrl_reg <= din;
  end

  always_ff @(posedge clk) begin
    if (rst)
      wdog_reg <= BYTE_RST;
    else if (wr_ok && addr == WDOG_OFS)
      wdog_reg <= din;
  end

  // ---------------------------------------------
  // time counters
  // ---------------------------------------------
  logic [7:0] cnt_reg [0:7];
  logic [7:0] cnt_next [0:7];
  logic [31:0] tick_reg, tick_max;
  logic tick, hold, load_cnt;
  assign tick_max = ctrl_reg[CTRL_SIGN_BIT]
    ? 32'(SEC_CYC + CAL_STEP_CYC * int'(ctrl_reg[4:0]) - 1)
    : 32'(SEC_CYC - CAL_STEP_CYC * int'(ctrl_reg[4:0]) - 1);
  assign tick = tick_reg >= tick_max;
  assign hold = ctrl_reg[CTRL_WRITE_BIT] | ctrl_reg[CTRL_READ_BIT];
  assign load_cnt = wr_ok && addr == CTRL_OFS &&
    ctrl_reg[CTRL_WRITE_BIT] && !din[CTRL_WRITE_BIT];

  always_ff @(posedge clk) begin
    if (rst || tick)
      tick_reg <= 32'h0000_0000;
    else
      tick_reg <= tick_reg + 32'h0000_0001;
  end

  // order: sec min hour day date month year century
  // BCD roll over
  always_comb begin
    for (int i = 0; i < 8; i++)
      cnt_next[i] = cnt_reg[i];
    cnt_next[0] = bcd_inc(cnt_reg[0]);
    if (cnt_reg[0] == 8'h59) begin
      cnt_next[0] = BYTE_RST;
      cnt_next[1] = bcd_inc(cnt_reg[1]);
      if (cnt_reg[1] == 8'h59) begin
        cnt_next[1] = BYTE_RST;
        cnt_next[2] = bcd_inc(cnt_reg[2]);
        if (cnt_reg[2] == 8'h23) begin
          cnt_next[2] = BYTE_RST;
          cnt_next[3] = (cnt_reg[3] == 8'h07) ? ONE_RST : bcd_inc(cnt_reg[3]);
          cnt_next[4] = bcd_inc(cnt_reg[4]);
          if (cnt_reg[4] == month_days(cnt_reg[5], cnt_reg[6])) begin
            cnt_next[4] = ONE_RST;
            cnt_next[5] = bcd_inc(cnt_reg[5]);
            if (cnt_reg[5] == 8'h12) begin
              cnt_next[5] = ONE_RST;
              cnt_next[6] = bcd_inc(cnt_reg[6]);
              if (cnt_reg[6] == 8'h99) begin
                cnt_next[6] = BYTE_RST;
                cnt_next[7] = bcd_inc(cnt_reg[7]);
              end
            end
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 8; i++)
        cnt_reg[i] <= (i == 3 || i == 4 || i == 5) ? ONE_RST : BYTE_RST;
      cnt_reg[7] <= CENTURY_RST;
    end else if (load_cnt) begin
      for (int i = 0; i < 8; i++)
        cnt_reg[i] <= tk_reg[i];
    end else if (tick) begin
      for (int i = 0; i < 8; i++)
        cnt_reg[i] <= cnt_next[i];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 8; i++)
        tk_reg[i] <= (i == 3 || i == 4 || i == 5) ? ONE_RST : BYTE_RST;
      tk_reg[7] <= CENTURY_RST;
    end else if (wr_ok && (addr >= SEC_OFS || addr == CENTURY_OFS)) begin
      tk_reg[tk_idx] <= din;
    end else if (tick && !hold) begin
      for (int i = 0; i < 8; i++)
        tk_reg[i] <= cnt_next[i];
    end
  end

  // ---------------------------------------------
  // alarm and watchdog
  // ---------------------------------------------
  logic al_match, wd_expire, kick_d_reg, flags_rd;
  logic [31:0] wd_cnt_reg, rst_cnt_reg;
  rd_state_t rd_state_reg, rd_state_next;
  assign al_match = tick && flags_reg[FLAG_AL_EN_BIT] &&
    cnt_next[4] == al_reg[0] && cnt_next[2] == al_reg[1] &&
    cnt_next[1] == al_reg[2] && cnt_next[0] == al_reg[3];
  assign flags_rd = ce & oe & ~we & ~pf & addr == FLAGS_OFS &
    rd_state_reg == RD_VALID;
  assign wd_expire = wdog_reg[6:0] != 7'h00 &&
    wd_cnt_reg >= 32'(WDOG_UNIT_CYC * int'(wdog_reg[6:0]) - 1);

  // read clears the alarm and watchdog flags but not the alarm enable bit; a new event wins
  always_ff @(posedge clk) begin
    if (rst) begin
      flags_reg <= BYTE_RST;
    end else begin
      if (wr_ok && addr == FLAGS_OFS)
        flags_reg[FLAG_AL_EN_BIT] <= din[FLAG_AL_EN_BIT];
      flags_reg[FLAG_AL_BIT] <= al_match | (flags_reg[FLAG_AL_BIT] & ~flags_rd);
      flags_reg[FLAG_WD_BIT] <= (wd_expire & wdog_reg[WDOG_STEER_BIT]) |
        (flags_reg[FLAG_WD_BIT] & ~flags_rd);
    end
  end

  // kick edge or config write restarts
  always_ff @(posedge clk) begin
    if (rst) begin
      kick_d_reg <= 1'b0;
      wd_cnt_reg <= 32'h0000_0000;
    end else begin
      kick_d_reg <= kick;
      if (kick != kick_d_reg || wd_expire || (wr_ok && addr == WDOG_OFS))
        wd_cnt_reg <= 32'h0000_0000;
      else
        wd_cnt_reg <= wd_cnt_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst)
      rst_cnt_reg <= 32'h0000_0000;
    else if (wd_expire && !wdog_reg[WDOG_STEER_BIT])
      rst_cnt_reg <= 32'(WDOG_RST_CYC);
    else if (rst_cnt_reg != 32'h0000_0000)
      rst_cnt_reg <= rst_cnt_reg - 32'h0000_0001;
  end

  assign alarm_or_freq_test_n_out = 1'b0;
  assign alarm_or_freq_test_n_oe = flags_reg[FLAG_AL_BIT] |
    flags_reg[FLAG_WD_BIT];
  assign wdog_reset_n_out = 1'b0;
  assign wdog_reset_n_oe = rst_cnt_reg != 32'h0000_0000;

  // ---------------------------------------------
  // read path
  // ---------------------------------------------
  logic [2:0] a_cnt_reg, e_cnt_reg, g_cnt_reg, h_cnt_reg;
  logic [14:0] addr_d_reg;
  logic [7:0] rd_byte, out_reg;
  logic rd_en, addr_chg, timed;
  assign rd_en = ce & oe & ~we & ~pf;
  assign addr_chg = addr != addr_d_reg;
  assign timed = a_cnt_reg >= ADDR_ACCESS_CYC &&
    e_cnt_reg >= SELECT_ACCESS_CYC && g_cnt_reg >= OUTPUT_ACCESS_CYC;

  always_comb begin
    rd_byte = BYTE_RST;
    if (32'(addr) < USER_BYTES)
      rd_byte = mem[addr];
    else if (addr >= SEC_OFS || addr == CENTURY_OFS)
      rd_byte = tk_reg[tk_idx];
    else if (addr >= AL_DATE_OFS && addr <= AL_SEC_OFS)
      rd_byte = al_reg[2'(addr - AL_DATE_OFS)];
    else if (addr == FLAGS_OFS)
      rd_byte = flags_reg;
    else if (addr == WDOG_OFS)
      rd_byte = wdog_reg;
    else if (addr == CTRL_OFS)
      rd_byte = ctrl_reg;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      addr_d_reg <= 15'h0000;
      a_cnt_reg <= 3'h0;
      e_cnt_reg <= 3'h0;
      g_cnt_reg <= 3'h0;
    end else begin
      addr_d_reg <= addr;
      a_cnt_reg <= addr_chg ? 3'h0 :
        (a_cnt_reg == 3'h7 ? a_cnt_reg : a_cnt_reg + 3'h1);
      e_cnt_reg <= !(ce && !pf) ? 3'h0 :
        (e_cnt_reg == 3'h7 ? e_cnt_reg : e_cnt_reg + 3'h1);
      g_cnt_reg <= !oe ? 3'h0 :
        (g_cnt_reg == 3'h7 ? g_cnt_reg : g_cnt_reg + 3'h1);
    end
  end

  always_comb begin
    rd_state_next = rd_state_reg;
    case (rd_state_reg)
      RD_IDLE: rd_state_next = rd_en ? RD_WAIT : RD_IDLE;
      RD_WAIT: rd_state_next = !rd_en ? RD_IDLE : (timed ? RD_VALID : RD_WAIT);
      RD_VALID: rd_state_next = !rd_en ? RD_IDLE : (addr_chg ? RD_HOLD :
        RD_VALID);
      RD_HOLD: rd_state_next = !rd_en ? RD_IDLE :
        (h_cnt_reg >= OUTPUT_HOLD_CYC - 3'h1 ? RD_WAIT : RD_HOLD);
      default: rd_state_next = RD_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_state_reg <= RD_IDLE;
      h_cnt_reg <= 3'h0;
    end else begin
      rd_state_reg <= rd_state_next;
      h_cnt_reg <= rd_state_reg == RD_HOLD ? h_cnt_reg + 3'h1 : 3'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst)
      out_reg <= FILL_BYTE;
    else if (rd_state_next == RD_VALID && rd_state_reg != RD_VALID)
      out_reg <= rd_byte;
    else if (rd_state_next != RD_VALID && rd_state_next != RD_HOLD)
      out_reg <= FILL_BYTE;
  end

  assign data_bus_out = out_reg;
  // drive only with select and output
  assign data_bus_oe = rd_en;

  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  drive_gate_a: assert property (data_bus_oe |-> ce && oe)
    else $error("data driven without select and output");
  write_float_a: assert property (we |-> !data_bus_oe)
    else $error("data driven during write");
  fail_float_a: assert property (pf |-> !data_bus_oe)
    else $error("data driven under power fail");
  fault_write_a: assert property (pf && addr == CTRL_OFS
    |=> $stable(ctrl_reg)) else $error("write under power fail");
  access_wait_a: assert property (rd_en && !$past(rd_en)
    |-> out_reg == FILL_BYTE ##1 out_reg == FILL_BYTE)
    else $error("data before access delay");
  addr_hold_a: assert property (rd_state_reg == RD_VALID && rd_en &&
    addr_chg |=> $stable(out_reg)) else $error("hold not kept");
  refresh_a: assert property (tick && !hold && !wr_ok
    |=> tk_reg[0] == cnt_reg[0]) else $error("bytes not refreshed");
  hold_frozen_a: assert property (hold && !wr_ok
    |=> $stable(tk_reg[0])) else $error("bytes changed while held");
  sec_wrap_a: assert property (tick && cnt_reg[0] == 8'h59 && !load_cnt
    |=> cnt_reg[0] == 8'h00) else $error("seconds did not wrap");
  feb_end_a: assert property (tick && cnt_reg[5] == 8'h02 &&
    cnt_reg[6] == 8'h23 && cnt_reg[4] == 8'h28 && cnt_reg[2] == 8'h23 &&
    cnt_reg[1] == 8'h59 && cnt_reg[0] == 8'h59 && !load_cnt
    |=> cnt_reg[5] == 8'h03 && cnt_reg[4] == 8'h01)
    else $error("february not ended");
  alarm_pin_a: assert property (al_match |=> alarm_or_freq_test_n_oe)
    else $error("alarm pin not pulled");
  wd_react_a: assert property (wd_expire |=> wdog_reset_n_oe ||
    flags_reg[FLAG_WD_BIT]) else $error("watchdog expiry lost");
  read_cov_c: cover property (rd_state_reg == RD_VALID && data_bus_oe);
  hold_cov_c: cover property (rd_state_reg == RD_HOLD);
  alarm_cov_c: cover property (al_match);
  wd_cov_c: cover property (wd_expire);
endmodule : rtc_sram_parallel_port

/* dv/host_bus_model.sv */
`timescale 1ns/1ns
// ----------------------
// host on memory bus
// ----------------------
module host_bus_model (
  input wire logic clk,
  output logic [14:0] addr_bus,
  output logic [7:0] data_bus_in,
  output logic chip_en_n,
  output logic out_en_n,
  output logic write_en_n,
  input wire logic [7:0] data_bus_out,
  input wire logic data_bus_oe,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic oe_seen
);
  logic drv = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] idle_pat = 8'h5A;
  logic [7:0] samp [0:15];
  initial begin
    addr_bus = 15'h0000;
    chip_en_n = 1'b1;
    out_en_n = 1'b1;
    write_en_n = 1'b1;
    rd_data = 8'h00;
    rd_valid = 1'b0;
    oe_seen = 1'b0;
  end
  // released lines change every cycle
  always @(negedge clk) idle_pat <= ~idle_pat;
  assign data_bus_in = data_bus_oe ? data_bus_out : drv ? wdata : idle_pat;
  // write with held address and data
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    oe_seen = 1'b0;
    @(negedge clk);
    addr_bus = a;
    wdata = d;
    drv = 1'b1;
    chip_en_n = 1'b0;
    write_en_n = 1'b0;
    repeat (4) begin
      @(negedge clk);
      oe_seen |= data_bus_oe;
    end
    chip_en_n = 1'b1;
    write_en_n = 1'b1;
    @(negedge clk);
    drv = 1'b0;
  endtask : wr
  task automatic rd(input logic [14:0] a, input logic [14:0] b,
                    input logic ce_v, input logic rep);
    oe_seen = 1'b0;
    @(negedge clk);
    addr_bus = a;
    chip_en_n = ce_v;
    out_en_n = 1'b0;
    for (int i = 0; i < 16; i++) begin
      @(negedge clk);
      samp[i] = data_bus_in;
      oe_seen |= data_bus_oe;
      if (i == 7) addr_bus = b;
    end
    rd_data = samp[15];
    rd_valid = rep;
    @(negedge clk);
    rd_valid = 1'b0;
    chip_en_n = 1'b1;
    out_en_n = 1'b1;
  endtask : rd
endmodule : host_bus_model

/* dv/tb.sv */
`timescale 1ns/1ns
// ----------------
// testbench
// ----------------
module tb import rtc_pkg::*; ();
  localparam int SEC = 20;
  localparam int WRST = 5;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [14:0] addr_bus;
  logic [7:0] data_bus_in;
  logic [7:0] data_bus_out;
  logic data_bus_oe;
  logic chip_en_n;
  logic out_en_n;
  logic write_en_n;
  logic power_fail = 1'b0;
  logic battery_mode = 1'b0;
  logic kick = 1'b0;
  logic irq_oe;
  logic wd_oe;
  logic irq_out;
  logic wd_out;
  logic [7:0] rd_data;
  logic rd_valid;
  logic oe_seen;
  logic [7:0] exp_q [$];
  int n_mismatch = 0;
  int check_count = 0;
  rtc_sram_parallel_port #(.SEC_CYC(SEC), .CAL_STEP_CYC(0),
    .WDOG_UNIT_CYC(4), .WDOG_RST_CYC(WRST)) DUT (
    .clk(clk), .rst(rst), .addr_bus(addr_bus), .data_bus_in(data_bus_in),
    .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe),
    .chip_en_n(chip_en_n), .out_en_n(out_en_n), .write_en_n(write_en_n),
    .power_fail(power_fail), .battery_mode(battery_mode),
    .watchdog_kick_in(kick), .alarm_or_freq_test_n_out(irq_out),
    .alarm_or_freq_test_n_oe(irq_oe), .wdog_reset_n_out(wd_out),
    .wdog_reset_n_oe(wd_oe));
  host_bus_model host (.clk(clk), .addr_bus(addr_bus),
    .data_bus_in(data_bus_in), .chip_en_n(chip_en_n), .out_en_n(out_en_n),
    .write_en_n(write_en_n), .data_bus_out(data_bus_out),
    .data_bus_oe(data_bus_oe), .rd_data(rd_data), .rd_valid(rd_valid),
    .oe_seen(oe_seen));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_byte
  task automatic chk_bit(input logic g, input logic e);
    chk_byte({7'h00, g}, {7'h00, e});
  endtask : chk_bit
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    host.wr(a, d);
    chk_bit(oe_seen, 1'b0);
  endtask : wr
  task automatic rd(input logic [14:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.rd(a, a, 1'b0, 1'b1);
  endtask : rd
  task automatic set_time(input logic [7:0] yr, mo, dt, hr, mn, sc);
    wr(CTRL_OFS, 8'h80);
    wr(YEAR_OFS, yr);
    wr(MONTH_OFS, mo);
    wr(DATE_OFS, dt);
    wr(HOUR_OFS, hr);
    wr(MIN_OFS, mn);
    wr(SEC_OFS, sc);
    wr(CTRL_OFS, 8'h00);
  endtask : set_time
  // read results checked in order
  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      chk_byte(rd_data, exp_q.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_sim();
  end
  initial begin
    logic [14:0] a;
    logic [7:0] d;
    logic [47:0] tc [0:3];
    logic [7:0] yr, mo, dt, eyr, emo, edt;
    int n;
    tc[0] = 48'h230228_230301;
    tc[1] = 48'h240228_240229;
    tc[2] = 48'h240430_240501;
    tc[3] = 48'h241231_250101;
    n = $urandom(42);
    repeat (4) @(negedge clk);
    rst = 1'b0;
    chk_bit(data_bus_oe, 1'b0);
    chk_bit(irq_oe, 1'b0);
    chk_bit(wd_oe, 1'b0);
    for (int i = 0; i < 10; i++) begin
      a = (i == 0) ? 15'h0000 : (i == 1) ? 15'h7FEF
        : 15'($urandom_range(32751));
      d = 8'($urandom());
      wr(a, d);
      rd(a, d);
    end
    wr(15'h7FF0, 8'hA5);
    rd(15'h7FF0, 8'h00);
    for (int i = 0; i < 6; i++) begin
      a = (i < 4) ? AL_DATE_OFS + 15'(i) : (i == 4) ? WDOG_OFS : CTRL_OFS;
      d = (i < 4) ? 8'($urandom()) : (i == 4) ? 8'h80 : 8'h25;
      wr(a, d);
      rd(a, d);
    end
    wr(CTRL_OFS, 8'h00);
    wr(WDOG_OFS, 8'h00);
    a = 15'h1234;
    wr(a, 8'h3C);
    battery_mode = 1'b1;
    wr(a, 8'hC3);
    battery_mode = 1'b0;
    power_fail = 1'b1;
    wr(a, 8'hC3);
    wr(CTRL_OFS, 8'h80);
    host.rd(a, a, 1'b0, 1'b0);
    chk_bit(oe_seen, 1'b0);
    power_fail = 1'b0;
    host.rd(a, a, 1'b1, 1'b0);
    chk_bit(oe_seen, 1'b0);
    rd(CTRL_OFS, 8'h00);
    wr(15'h0BCD, 8'h96);
    exp_q.push_back(8'h96);
    host.rd(a, 15'h0BCD, 1'b0, 1'b1);
    chk_byte(host.samp[3], 8'h00);
    chk_byte(host.samp[7], 8'h3C);
    chk_byte(host.samp[10], 8'h3C);
    d = 8'hFF;
    for (int i = 9; i < 13; i++) if (host.samp[i] === 8'h00) d = 8'h00;
    chk_byte(d, 8'h00);
    for (int i = 0; i < 4; i++) begin
      {yr, mo, dt, eyr, emo, edt} = tc[i];
      set_time(yr, mo, dt, 8'h23, 8'h59, 8'h59);
      repeat (SEC + 10) @(negedge clk);
      wr(CTRL_OFS, 8'h40);
      rd(MIN_OFS, 8'h00);
      rd(HOUR_OFS, 8'h00);
      rd(DATE_OFS, edt);
      rd(MONTH_OFS, emo);
      rd(YEAR_OFS, eyr);
      wr(CTRL_OFS, 8'h00);
    end
    wr(AL_DATE_OFS, 8'h05);
    wr(AL_HOUR_OFS, 8'h12);
    wr(AL_MIN_OFS, 8'h00);
    wr(AL_SEC_OFS, 8'h03);
    set_time(8'h24, 8'h03, 8'h05, 8'h12, 8'h00, 8'h00);
    wr(FLAGS_OFS, 8'h80);
    chk_bit(irq_oe, 1'b0);
    repeat (4 * SEC) @(negedge clk);
    chk_bit(irq_oe, 1'b1);
    chk_bit(irq_out, 1'b0);
    rd(FLAGS_OFS, 8'h81);
    chk_bit(irq_oe, 1'b0);
    wr(FLAGS_OFS, 8'h00);
    wr(WDOG_OFS, 8'h0A);
    d = 8'h00;
    for (int i = 0; i < 100; i++) begin
      @(negedge clk);
      if (i % 8 == 0) kick = ~kick;
      if (wd_oe !== 1'b0) d = 8'h01;
    end
    chk_byte(d, 8'h00);
    n = 0;
    while (wd_oe !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    chk_bit(wd_oe, 1'b1);
    chk_bit(wd_out, 1'b0);
    n = 0;
    while (wd_oe === 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk_byte(8'(n), 8'(WRST));
    wr(WDOG_OFS, 8'h00);
    wr(WDOG_OFS, 8'h81);
    n = 0;
    while (irq_oe !== 1'b1 && n < 30) begin
      @(negedge clk);
      n++;
    end
    chk_bit(irq_oe, 1'b1);
    wr(WDOG_OFS, 8'h00);
    rd(FLAGS_OFS, 8'h02);
    chk_bit(irq_oe, 1'b0);
    repeat (3) @(negedge clk);
    end_sim();
  end
endmodule : tb
